// file: evas_top.sv
// evas_top: exception vector address select with its register file
// assumes: pipeline presents exception class and status fields each cycle,
// software uses a plain address/strobe port with read data one cycle later
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module evas_top
  import evas_pkg::*;
#(
  parameter int unsigned NUM_VP = 4,
  parameter int unsigned VP_W   = 2
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // register port
  input  wire logic [11:0]       reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [31:0]       reg_rdata_o,
  // pipeline exception request
  input  wire logic [2:0]        exc_type_i,
  input  wire logic              exc_take_i,
  input  wire logic [VP_W-1:0]   virtual_processor_i,
  // processor state affecting the vector
  input  wire logic              boot_exception_status_i,
  input  wire logic              exception_level_i,
  input  wire logic              interrupt_dedicated_vector_i,
  input  wire logic              debug_segment_enable_i,
  input  wire logic              relocated_debug_vector_select_i,
  input  wire logic              probe_trap_select_i,
  input  wire logic [63:0]       exception_base_register_i,
  input  wire logic [31:0]       debug_vector_address_i,
  // vector result
  output logic      [63:0]       vector_o
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [NUM_VP-1:0][31:0] rst_base;
    logic [31:0]             boot_base;
    logic [VP_W-1:0]         vp_sel;
    logic [63:0]             last_vec;
    logic [2:0]              last_type;
    logic [VP_W-1:0]         last_vp;
    logic [15:0]             take_cnt;
    logic [31:0]             rdata;
  } evas_state_s;

  evas_state_s st_ff;
  evas_state_s nxt_st;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [11:0] addr, input logic [11:0] off);
    return addr == off;
  endfunction : hit

  logic wr_vp_sel;
  logic wr_rst;
  logic wr_boot;

  assign wr_vp_sel = reg_wr_i && hit(reg_addr_i, EVAS_OFF_VP_SEL);
  assign wr_rst    = reg_wr_i && hit(reg_addr_i, EVAS_OFF_RST_BASE);
  assign wr_boot   = reg_wr_i && hit(reg_addr_i, EVAS_OFF_BOOT);

  // ------------------------------------------------------------
  // vector calculator
  // ------------------------------------------------------------
  evas_calc_if cif ();

  assign cif.exc_type  = evas_exc_e'(exc_type_i);
  assign cif.boot_exception_status       = boot_exception_status_i;
  assign cif.exception_level       = exception_level_i;
  assign cif.iv        = interrupt_dedicated_vector_i;
  assign cif.dseg_en   = debug_segment_enable_i;
  assign cif.relocated_debug_vector_select     = relocated_debug_vector_select_i;
  assign cif.probe     = probe_trap_select_i;
  assign cif.exception_base_register     = exception_base_register_i;
  assign cif.dbg_addr  = debug_vector_address_i;
  assign cif.rst_word  = st_ff.rst_base[virtual_processor_i];
  assign cif.boot_word = st_ff.boot_base;

  evas_vec_calc u_calc (
    .cif (cif.calc)
  );

  assign vector_o = cif.vector;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = 32'h0000_0000;
    if (wr_vp_sel) begin
      nxt_st.vp_sel = reg_wdata_i[VP_W-1:0];
    end
    if (wr_rst) begin
      nxt_st.rst_base[st_ff.vp_sel] = reg_wdata_i & EVAS_RST_WR_MASK;
    end
    if (wr_boot) begin
      nxt_st.boot_base = reg_wdata_i & EVAS_BOOT_WR_MASK;
    end
    if (exc_take_i) begin
      nxt_st.last_vec  = cif.vector;
      nxt_st.last_type = exc_type_i;
      nxt_st.last_vp   = virtual_processor_i;
      nxt_st.take_cnt  = st_ff.take_cnt + 16'h0001;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        EVAS_OFF_VP_SEL: begin
          nxt_st.rdata = {{(32-VP_W){1'b0}}, st_ff.vp_sel};
        end
        EVAS_OFF_RST_BASE: begin
          nxt_st.rdata = st_ff.rst_base[st_ff.vp_sel];
        end
        EVAS_OFF_BOOT: begin
          nxt_st.rdata = st_ff.boot_base;
        end
        EVAS_OFF_LAST_LO: begin
          nxt_st.rdata = st_ff.last_vec[31:0];
        end
        EVAS_OFF_LAST_HI: begin
          nxt_st.rdata = st_ff.last_vec[63:32];
        end
        EVAS_OFF_LAST_INF: begin
          nxt_st.rdata = {st_ff.take_cnt, 8'h00,
                          {(5-VP_W){1'b0}}, st_ff.last_vp, st_ff.last_type};
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NUM_VP; i++) begin
        st_ff.rst_base[i] <= EVAS_RST_BASE_RST;
      end
      st_ff.boot_base <= EVAS_BOOT_RST;
      st_ff.vp_sel    <= '0;
      st_ff.last_vec  <= 64'h0000_0000_0000_0000;
      st_ff.last_type <= 3'h0;
      st_ff.last_vp   <= '0;
      st_ff.take_cnt  <= 16'h0000;
      st_ff.rdata     <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_o = st_ff.rdata;

endmodule : evas_top

// file: evas_pkg.sv
// evas_pkg: register map, field layout, reset values and vector constants
// assumes: shared by the vector select top and its address calculator
package evas_pkg;

  // ------------------------------------------------------------
  // register map (byte offsets on the plain register port)
  // ------------------------------------------------------------
  localparam int unsigned EVAS_ADDR_W = 12;
  localparam logic [11:0] EVAS_OFF_VP_SEL   = 12'h000;
  localparam logic [11:0] EVAS_OFF_RST_BASE = 12'h020;
  localparam logic [11:0] EVAS_OFF_LAST_LO  = 12'h100;
  localparam logic [11:0] EVAS_OFF_LAST_HI  = 12'h104;
  localparam logic [11:0] EVAS_OFF_LAST_INF = 12'h108;
  localparam logic [11:0] EVAS_OFF_BOOT     = 12'h680;

  // ------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------
  localparam int unsigned EVAS_FLD_SEL_BEV  = 0;
  localparam int unsigned EVAS_FLD_MODE     = 1;
  localparam int unsigned EVAS_FLD_BASE_LSB = 12;
  localparam logic [31:0] EVAS_RST_WR_MASK  = 32'hFFFF_F003;
  localparam logic [31:0] EVAS_BOOT_WR_MASK = 32'hFFFF_F002;
  localparam logic [31:0] EVAS_RST_BASE_RST = 32'hBFC0_0000;
  localparam logic [31:0] EVAS_BOOT_RST     = 32'hBFC0_0000;

  // ------------------------------------------------------------
  // address forming constants
  // ------------------------------------------------------------
  localparam logic [2:0]  EVAS_LEGACY_TOP   = 3'b101;
  localparam logic [31:0] EVAS_SEXT_HI      = 32'hFFFF_FFFF;
  localparam logic [31:0] EVAS_DIRECT_PHYSICAL_WINDOW_UC_HI = 32'h9000_0000;
  localparam logic [1:0]  EVAS_EXCEPTION_BASE_REGISTER_TOP    = 2'b10;
  localparam logic [63:0] EVAS_NMI_VEC      = 64'hFFFF_FFFF_BFC0_0000;
  localparam logic [63:0] EVAS_DBG_BOOT_VEC = 64'hFFFF_FFFF_BFC0_0480;
  localparam logic [63:0] EVAS_DBG_SEG_VEC  = 64'hFFFF_FFFF_FF20_0200;
  localparam logic [63:0] EVAS_DBG_SEG_NP   = 64'hFFFF_FFFF_FF20_0000;
  localparam logic [11:0] EVAS_OFS_BEV      = 12'h200;
  localparam logic [11:0] EVAS_OFS_TLB      = 12'h000;
  localparam logic [11:0] EVAS_OFS_CERR     = 12'h100;
  localparam logic [11:0] EVAS_OFS_GEN      = 12'h180;
  localparam logic [11:0] EVAS_OFS_INT      = 12'h200;

  // ------------------------------------------------------------
  // exception classes presented by the pipeline
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    EVAS_EXC_RESET = 3'b000,
    EVAS_EXC_NMI   = 3'b001,
    EVAS_EXC_DEBUG = 3'b010,
    EVAS_EXC_TLB   = 3'b011,
    EVAS_EXC_CERR  = 3'b100,
    EVAS_EXC_INT   = 3'b101,
    EVAS_EXC_OTHER = 3'b110
  } evas_exc_e;

endpackage : evas_pkg

// file: evas_calc_if.sv
// evas_calc_if: operands and result between the top and the calculator
// assumes: purely combinational traffic, no clock needed
`timescale 1ns/1ns
interface evas_calc_if;
  import evas_pkg::*;
  evas_exc_e   exc_type;
  logic        boot_exception_status;
  logic        exception_level;
  logic        iv;
  logic        dseg_en;
  logic        relocated_debug_vector_select;
  logic        probe;
  logic [63:0] exception_base_register;
  logic [31:0] dbg_addr;
  logic [31:0] rst_word;
  logic [31:0] boot_word;
  logic [63:0] vector;

  modport top  (output exc_type, boot_exception_status, exception_level, iv, dseg_en, relocated_debug_vector_select, probe,
                output exception_base_register, dbg_addr, rst_word, boot_word, input vector);
  modport calc (input exc_type, boot_exception_status, exception_level, iv, dseg_en, relocated_debug_vector_select, probe,
                input exception_base_register, dbg_addr, rst_word, boot_word, output vector);
endinterface : evas_calc_if

// file: evas_vec_calc.sv
// evas_vec_calc: combinational exception vector address calculator
// assumes: operands come stable from the top through evas_calc_if
`timescale 1ns/1ns
module evas_vec_calc
  import evas_pkg::*;
(
  // operands and result
  evas_calc_if.calc cif
);

  // ------------------------------------------------------------
  // region forming of a reset or boot base word
  // ------------------------------------------------------------
  function automatic logic [63:0] form_base(input logic [31:0] word);
    logic [63:0] v;
    v = '0;
    if (word[EVAS_FLD_MODE]) begin
      v = {EVAS_DIRECT_PHYSICAL_WINDOW_UC_HI, word[31:12], 12'h000};
    end else begin
      v = {EVAS_SEXT_HI, EVAS_LEGACY_TOP, word[28:12], 12'h000};
    end
    return v;
  endfunction : form_base

  logic [63:0] boot_vec;
  logic [63:0] rst_vec;
  logic [63:0] gen_base;
  logic [11:0] ofs;

  always_comb begin
    boot_vec = form_base(cif.boot_word);
    rst_vec  = form_base(cif.rst_word);
    gen_base = {cif.exception_base_register[63:32], EVAS_EXCEPTION_BASE_REGISTER_TOP, cif.exception_base_register[29:12], 12'h000};
    ofs      = EVAS_OFS_GEN;
    if (cif.exc_type == EVAS_EXC_TLB && !cif.exception_level) begin
      ofs = EVAS_OFS_TLB;
    end else if (cif.exc_type == EVAS_EXC_INT && cif.iv) begin
      ofs = EVAS_OFS_INT;
    end else if (cif.exc_type == EVAS_EXC_CERR) begin
      ofs = EVAS_OFS_CERR;
    end
    case (cif.exc_type)
      EVAS_EXC_RESET: begin
        cif.vector = cif.rst_word[EVAS_FLD_SEL_BEV] ? boot_vec : rst_vec;
      end
      EVAS_EXC_NMI: begin
        cif.vector = EVAS_NMI_VEC;
      end
      EVAS_EXC_DEBUG: begin
        if (!cif.dseg_en) begin
          cif.vector = cif.relocated_debug_vector_select ? {EVAS_SEXT_HI, cif.dbg_addr[31:7], 7'b000_0000}
                                 : EVAS_DBG_BOOT_VEC;
        end else begin
          cif.vector = cif.probe ? EVAS_DBG_SEG_VEC : EVAS_DBG_SEG_NP;
        end
      end
      EVAS_EXC_CERR: begin
        if (cif.boot_exception_status) begin
          cif.vector = boot_vec + {52'h0_0000_0000_0000, EVAS_OFS_BEV}
                       + {52'h0_0000_0000_0000, ofs};
        end else begin
          cif.vector = {cif.exception_base_register[63:30], 1'b1, cif.exception_base_register[28:12], ofs};
        end
      end
      default: begin
        if (cif.boot_exception_status) begin
          cif.vector = boot_vec + {52'h0_0000_0000_0000, EVAS_OFS_BEV}
                       + {52'h0_0000_0000_0000, ofs};
        end else begin
          cif.vector = gen_base + {52'h0_0000_0000_0000, ofs};
        end
      end
    endcase
  end

endmodule : evas_vec_calc

// file: evas_top_props.sv
// evas_top_props: port level checks on the vector select top
// assumes: bound onto evas_top, single clock domain
`timescale 1ns/1ns
module evas_top_props (
  // clock and register port
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  // exception state and result
  input wire logic [2:0]  exc_type_i,
  input wire logic        boot_exception_status_i,
  input wire logic        exception_level_i,
  input wire logic        interrupt_dedicated_vector_i,
  input wire logic        debug_segment_enable_i,
  input wire logic        relocated_debug_vector_select_i,
  input wire logic        probe_trap_select_i,
  input wire logic [63:0] exception_base_register_i,
  input wire logic [31:0] debug_vector_address_i,
  input wire logic [63:0] vector_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_dbg_off;
    exc_type_i == 3'h2 && !debug_segment_enable_i;
  endsequence
  sequence s_wr_then_rd;
    reg_wr_i && reg_addr_i == 12'h680 ##1 reg_rd_i && reg_addr_i == 12'h680;
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_NMI_FIXED: assert property (exc_type_i == 3'h1 |-> vector_o == 64'hFFFF_FFFF_BFC0_0000)
    else $error("nmi vector wrong");
  AST_DBG_RELOC: assert property (s_dbg_off ##0 relocated_debug_vector_select_i
    |-> vector_o == {32'hFFFF_FFFF, debug_vector_address_i[31:7], 7'h00})
    else $error("relocated debug vector wrong");
  AST_DBG_BOOT: assert property (s_dbg_off ##0 !relocated_debug_vector_select_i
    |-> vector_o == 64'hFFFF_FFFF_BFC0_0480) else $error("boot debug vector wrong");
  AST_DBG_SEG: assert property (exc_type_i == 3'h2 && debug_segment_enable_i
    && probe_trap_select_i |-> vector_o == 64'hFFFF_FFFF_FF20_0200)
    else $error("segment debug vector wrong");
  AST_RST_REGION: assert property (exc_type_i == 3'h0 |-> vector_o[11:0] == 12'h000
    && (vector_o[63:32] == 32'h9000_0000 || vector_o[63:29] == {32'hFFFF_FFFF, 3'b101}))
    else $error("reset vector outside region");
  AST_TLB_OFS: assert property (exc_type_i == 3'h3 && !boot_exception_status_i
    && !exception_level_i |-> vector_o == {exception_base_register_i[63:32], 2'b10,
    exception_base_register_i[29:12], 12'h000}) else $error("tlb refill vector wrong");
  AST_GEN_OFS: assert property (exc_type_i == 3'h6 && !boot_exception_status_i
    |-> vector_o[11:0] == 12'h180 && vector_o[31:30] == 2'b10)
    else $error("general vector wrong");
  AST_INT_DED: assert property (exc_type_i == 3'h5 && !boot_exception_status_i
    && interrupt_dedicated_vector_i |-> vector_o[11:0] == 12'h200)
    else $error("interrupt vector wrong");
  AST_BOOT_REGION: assert property (exc_type_i == 3'h6 && boot_exception_status_i
    |-> vector_o[11:0] == 12'h380
    && (vector_o[63:32] == 32'h9000_0000 || vector_o[63:29] == {32'hFFFF_FFFF, 3'b101}))
    else $error("boot based vector wrong");
  AST_BOOT_WR: assert property (s_wr_then_rd
    |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'hFFFF_F002))
    else $error("boot word readback wrong");
endmodule : evas_top_props

// file: evas_pipe_model.sv
// evas_pipe_model: pipeline and kernel side presenting exception state
// assumes: the bench hands it a fresh random word every clock
`timescale 1ns/1ns
module evas_pipe_model (
  // clock and random source
  input  wire logic        clk_i,
  input  wire logic [63:0] rnd_i,
  // {type, take, vp, bev, exl, iv, dseg, relocated_debug_vector_select, probe}, base, debug address
  output logic      [11:0] ctl_o = 12'h000,
  output logic      [63:0] exception_base_register_o = 64'h0000_0000_0000_0000,
  output logic      [31:0] dva_o = 32'h0000_0000
);
  // kernel wide segments assumed on before wide vectors are used, no pin for it
  always @(posedge clk_i) begin
    ctl_o   <= rnd_i[11:0];
    exception_base_register_o <= {rnd_i[40:9], rnd_i[63:32]};
    dva_o   <= rnd_i[50:19];
  end
endmodule : evas_pipe_model

// file: evas_top_test.sv
// evas_top_test: self-checking bench for the exception vector select
// assumes: evas_pkg, evas_top, evas_pipe_model and evas_top_props compiled first
`timescale 1ns/1ns
module evas_top_test;
  import evas_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [63:0] vector_o;
  logic [63:0] rnd = 64'h0000_0000_0000_0059;
  logic [11:0] ctl;
  logic [63:0] exception_base_register;
  logic [31:0] dva;
  logic [31:0] rst_w [4];
  logic [31:0] boot_w;
  logic [1:0]  m_sel = 2'h0;
  logic [63:0] m_last = 64'h0000_0000_0000_0000;
  logic [63:0] m_plast = 64'h0000_0000_0000_0000;
  logic [31:0] m_inf = 32'h0000_0000;
  logic [31:0] m_pinf = 32'h0000_0000;
  int          fail_count = 0;
  int          check_count = 0;
  always #50 clk_i = ~clk_i;
  function automatic logic [63:0] xs(input logic [63:0] x);
    logic [63:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 7);
    xs = y ^ (y << 17);
  endfunction : xs
  always @(posedge clk_i) rnd <= xs(rnd);
  evas_pipe_model evas_pipe_model_inst (.clk_i(clk_i), .rnd_i(rnd), .ctl_o(ctl),
    .exception_base_register_o(exception_base_register), .dva_o(dva));
  evas_top evas_top_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .exc_type_i(ctl[11:9]), .exc_take_i(ctl[8]),
    .virtual_processor_i(ctl[7:6]), .boot_exception_status_i(ctl[5]),
    .exception_level_i(ctl[4]), .interrupt_dedicated_vector_i(ctl[3]),
    .debug_segment_enable_i(ctl[2]), .relocated_debug_vector_select_i(ctl[1]),
    .probe_trap_select_i(ctl[0]), .exception_base_register_i(exception_base_register),
    .debug_vector_address_i(dva), .vector_o(vector_o));
  // ----------------------------------------
  // reference model
  // ----------------------------------------
  function automatic logic [63:0] vb(input logic [31:0] w);
    vb = w[1] ? {32'h9000_0000, w[31:12], 12'h000} : {32'hFFFF_FFFF, 3'b101, w[28:12], 12'h000};
  endfunction : vb
  function automatic logic [63:0] exp_vec();
    logic [63:0] bb;
    logic [11:0] ofs;
    bb = vb(boot_w);
    ofs = (ctl[11:9] == 3'h3 && !ctl[4]) ? 12'h000 : (ctl[11:9] == 3'h5 && ctl[3]) ? 12'h200
      : 12'h180;
    case (ctl[11:9])
      3'h0: exp_vec = rst_w[ctl[7:6]][0] ? bb : vb(rst_w[ctl[7:6]]);
      3'h1: exp_vec = 64'hFFFF_FFFF_BFC0_0000;
      3'h2: exp_vec = !ctl[2] ? (ctl[1] ? {32'hFFFF_FFFF, dva[31:7], 7'h00}
        : 64'hFFFF_FFFF_BFC0_0480) : (ctl[0] ? 64'hFFFF_FFFF_FF20_0200
        : 64'hFFFF_FFFF_FF20_0000);
      3'h4: exp_vec = ctl[5] ? bb + 64'h0000_0300 : {exception_base_register[63:30], 1'b1, exception_base_register[28:12], 12'h100};
      default: exp_vec = ctl[5] ? bb + 64'h0000_0200 + ofs
        : {exception_base_register[63:32], 2'b10, exception_base_register[29:12], ofs};
    endcase
  endfunction : exp_vec
  // register mirror and capture model, updated on the edges the design samples
  always @(posedge clk_i) begin
    m_plast <= m_last;
    m_pinf  <= m_inf;
    if (!rst_b_i) begin
      rst_w  <= '{default: EVAS_RST_BASE_RST};
      boot_w <= EVAS_BOOT_RST;
      m_sel  <= 2'h0;
      m_last <= 64'h0000_0000_0000_0000;
      m_inf  <= 32'h0000_0000;
    end else begin
      if (reg_wr_i && reg_addr_i == EVAS_OFF_VP_SEL) m_sel <= reg_wdata_i[1:0];
      if (reg_wr_i && reg_addr_i == EVAS_OFF_RST_BASE) rst_w[m_sel] <= reg_wdata_i & EVAS_RST_WR_MASK;
      if (reg_wr_i && reg_addr_i == EVAS_OFF_BOOT) boot_w <= reg_wdata_i & EVAS_BOOT_WR_MASK;
      if (ctl[8]) m_last <= exp_vec();
      if (ctl[8]) m_inf <= {m_inf[31:16] + 16'h0001, 8'h00, 3'b000, ctl[7:6], ctl[11:9]};
    end
  end
  // ----------------------------------------
  // bus, compare and closing tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= a;
    reg_wdata_i <= d;
  endtask : bus
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
    bus(1'b0, 1'b0, a, 32'h0000_0000);
    @(negedge clk_i);
    chk(nm, {32'h0000_0000, reg_rdata_o}, {32'h0000_0000, exp});
  endtask : rd
  task automatic rdl(input logic [11:0] a, input string nm);
    bus(1'b0, 1'b1, a, 32'h0000_0000);
    bus(1'b0, 1'b0, a, 32'h0000_0000);
    @(negedge clk_i);
    chk(nm, {32'h0000_0000, reg_rdata_o}, {32'h0000_0000, (a == EVAS_OFF_LAST_LO) ? m_plast[31:0]
      : (a == EVAS_OFF_LAST_HI) ? m_plast[63:32] : m_pinf});
  endtask : rdl
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    logic [1:0]  v;
    logic [31:0] w;
    logic [31:0] b;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 1'b0, 12'h000, 32'(k));
      rd(12'h020, 32'hBFC0_0000, "reset_word");
    end
    rd(12'h680, 32'hBFC0_0000, "boot_word");
    rd(12'hFFC, 32'h0000_0000, "unmapped");
    for (int i = 0; i < 300; i++) begin
      v = rnd[1:0];
      w = rnd[63:32];
      b = rnd[45:14];
      bus(1'b1, 1'b0, 12'h000, {30'h0000_0000, v});
      bus(1'b1, 1'b0, 12'h020, w);
      bus(1'b1, 1'b0, 12'h680, b);
      rd(12'h680, b & EVAS_BOOT_WR_MASK, "boot_word");
      rd(12'h020, w & EVAS_RST_WR_MASK, "reset_word");
      rd(12'h000, {30'h0000_0000, v}, "vp_select");
      repeat (8) begin
        @(negedge clk_i);
        chk("vector", vector_o, exp_vec());
      end
      rdl(12'h100, "last_vector_lo");
      rdl(12'h104, "last_vector_hi");
      rdl(12'h108, "last_info");
    end
    end_sim();
  end
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
endmodule : evas_top_test
bind evas_top evas_top_props evas_top_props_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .exc_type_i(exc_type_i),
  .boot_exception_status_i(boot_exception_status_i), .exception_level_i(exception_level_i),
  .interrupt_dedicated_vector_i(interrupt_dedicated_vector_i),
  .debug_segment_enable_i(debug_segment_enable_i),
  .relocated_debug_vector_select_i(relocated_debug_vector_select_i),
  .probe_trap_select_i(probe_trap_select_i),
  .exception_base_register_i(exception_base_register_i),
  .debug_vector_address_i(debug_vector_address_i), .vector_o(vector_o));
